// ---- shared/cmd_decode_pkg.sv ----
// constants, field layout and scheme codes of the start/stop/direction decoder
// Behaviour
// - Scheme zero: no start from this location
// - Scheme one: start on trigger, stop when low
// - Trigger kind picks rising edge or high level
// - Scheme two: source two chooses start direction
// - Scheme three: forward/reverse starts, both high or both low stop
// - Scheme four: rise starts, source two low stops
// - Scheme four always uses edge, ignores kind
// - Scheme four: source two low disables panel keys
// - Reset selects start with direction input scheme
package cmd_decode_pkg;

   typedef enum logic [2:0] {
      not_selected               = 3'b000,
      single_source_start        = 3'b001,
      start_with_direction_input = 3'b010,
      start_reverse_split        = 3'b011,
      pulse_start_held_stop      = 3'b100
   } scheme_e;

   localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
   localparam int unsigned ADDR_LSB    = 2;

   // control word layout
   localparam int unsigned SEL_LSB  = 0;
   localparam int unsigned SEL_W    = 3;
   localparam int unsigned KIND_BIT = 4;
   localparam logic [2:0]  SEL_DEFAULT  = 3'h2;
   localparam logic        KIND_DEFAULT = 1'b0;
   localparam logic        KIND_EDGE    = 1'b0;
   localparam logic        KIND_LEVEL   = 1'b1;

   // status word layout
   localparam int unsigned ST_RUN   = 0;
   localparam int unsigned ST_REV   = 1;
   localparam int unsigned ST_PANEL = 2;
   localparam int unsigned ST_SRC1  = 3;
   localparam int unsigned ST_SRC2  = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- hw/start_stop_direction_decoder.sv ----
// start/stop/direction decoder for external_location_one with AXI4-Lite control
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
module start_stop_direction_decoder
   import cmd_decode_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        first_command_source,
   input  wire logic        second_command_source,
   output logic             run_command,
   output logic             reverse_command,
   output logic             panel_keys_enable
);

   function automatic logic addr_is(input logic [31:0] a, input logic [31:0] reg_addr);
      addr_is = (a[31:ADDR_LSB] == reg_addr[31:ADDR_LSB]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register bus

   logic [31:0] awaddr_r;
   logic        aw_held_r;
   logic        w_held_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic [2:0]  sel_r;
   logic        kind_r;
   logic        run_r;
   logic        rev_r;
   logic        panel_r;
   logic        src1_prev_r;
   logic        src2_prev_r;
   logic        do_write;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign do_write      = aw_held_r && w_held_r && !bvalid_r;

   // address and data may arrive in either order; held until both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 32'h0000_0000;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (addr_is(awaddr_r, ADDR_CTRL) || addr_is(awaddr_r, ADDR_STATUS)) ?
                     RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // control word lives in byte lane 0; status is read-only, writes ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_r  <= SEL_DEFAULT;
         kind_r <= KIND_DEFAULT;
      end else if (do_write && addr_is(awaddr_r, ADDR_CTRL) && wstrb_r[0]) begin
         sel_r  <= wdata_r[SEL_LSB +: SEL_W];
         kind_r <= wdata_r[KIND_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
         if (addr_is(s_axi_araddr, ADDR_CTRL)) begin
            rdata_r[SEL_LSB +: SEL_W] <= sel_r;
            rdata_r[KIND_BIT]         <= kind_r;
         end else if (addr_is(s_axi_araddr, ADDR_STATUS)) begin
            rdata_r[ST_RUN]   <= run_r;
            rdata_r[ST_REV]   <= rev_r;
            rdata_r[ST_PANEL] <= panel_r;
            rdata_r[ST_SRC1]  <= first_command_source;
            rdata_r[ST_SRC2]  <= second_command_source;
         end else begin
            rresp_r <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command decode

   logic rise1;
   logic rise2;
   logic cond1;
   logic cond2;
   logic run_nxt;
   logic rev_nxt;

   // previous samples; history cleared so a source high at reset release counts as a rise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src1_prev_r <= 1'b0;
         src2_prev_r <= 1'b0;
      end else begin
         src1_prev_r <= first_command_source;
         src2_prev_r <= second_command_source;
      end
   end

   assign rise1 = first_command_source && !src1_prev_r;
   assign rise2 = second_command_source && !src2_prev_r;
   assign cond1 = (kind_r == KIND_LEVEL) ? first_command_source : rise1;
   assign cond2 = (kind_r == KIND_LEVEL) ? second_command_source : rise2;

   // stop terms are tested first in every scheme
   always_comb begin
      run_nxt = run_r;
      rev_nxt = rev_r;
      case (sel_r)
         single_source_start: begin
            if (!first_command_source) begin
               run_nxt = 1'b0;
            end else if (cond1) begin
               run_nxt = 1'b1;
               rev_nxt = 1'b0;
            end
         end
         start_with_direction_input: begin
            if (!first_command_source) begin
               run_nxt = 1'b0;
            end else if (cond1) begin
               run_nxt = 1'b1;
               rev_nxt = second_command_source;
            end
         end
         start_reverse_split: begin
            if (first_command_source == second_command_source) begin
               run_nxt = 1'b0;
            end else if (cond1) begin
               run_nxt = 1'b1;
               rev_nxt = 1'b0;
            end else if (cond2) begin
               run_nxt = 1'b1;
               rev_nxt = 1'b1;
            end
         end
         pulse_start_held_stop: begin
            if (!second_command_source) begin
               run_nxt = 1'b0;
            end else if (rise1) begin
               run_nxt = 1'b1;
               rev_nxt = 1'b0;
            end
         end
         default: begin
            run_nxt = 1'b0;
            rev_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_r <= 1'b0;
         rev_r <= 1'b0;
      end else begin
         run_r <= run_nxt;
         rev_r <= rev_nxt;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         panel_r <= 1'b1;
      end else begin
         panel_r <= !(sel_r == pulse_start_held_stop && !second_command_source);
      end
   end

   assign run_command       = run_r;
   assign reverse_command   = rev_r;
   assign panel_keys_enable = panel_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_sel0_idle;
      sel_r == not_selected |=> !run_command;
   endproperty
   a_sel0_idle: assert property (p_sel0_idle) else $error("run while not selected");

   property p_one_stop;
      sel_r == single_source_start && !first_command_source |=> !run_command;
   endproperty
   a_one_stop: assert property (p_one_stop) else $error("scheme one did not stop");

   property p_edge_start;
      sel_r == single_source_start && kind_r == KIND_EDGE && first_command_source
         && !src1_prev_r |=> run_command && !reverse_command;
   endproperty
   a_edge_start: assert property (p_edge_start) else $error("edge start missed");

   property p_level_start;
      sel_r == single_source_start && kind_r == KIND_LEVEL && first_command_source
         ##1 sel_r == single_source_start && first_command_source |=> run_command;
   endproperty
   a_level_start: assert property (p_level_start) else $error("level start missed");

   property p_dir_rev;
      sel_r == start_with_direction_input && cond1 && second_command_source
         |=> run_command && reverse_command;
   endproperty
   a_dir_rev: assert property (p_dir_rev) else $error("direction not reverse");

   property p_both_stop;
      sel_r == start_reverse_split && first_command_source && second_command_source
         |=> !run_command;
   endproperty
   a_both_stop: assert property (p_both_stop) else $error("both high not stopped");

   property p_pulse_stop;
      sel_r == pulse_start_held_stop && !second_command_source |=> !run_command;
   endproperty
   a_pulse_stop: assert property (p_pulse_stop) else $error("held stop ignored");

   property p_pulse_no_level;
      sel_r == pulse_start_held_stop && kind_r == KIND_LEVEL && !run_command
         && first_command_source && src1_prev_r |=> !run_command;
   endproperty
   a_pulse_no_level: assert property (p_pulse_no_level) else $error("level started pulse");

   property p_panel_off;
      sel_r == pulse_start_held_stop && !second_command_source |=> !panel_keys_enable;
   endproperty
   a_panel_off: assert property (p_panel_off) else $error("panel keys not disabled");

   property p_reset_sel;
      $rose(aresetn) |-> sel_r == SEL_DEFAULT && !run_command;
   endproperty
   a_reset_sel: assert property (p_reset_sel) else $error("wrong scheme after reset");

   c_fwd_start: cover property (sel_r == start_reverse_split ##1 run_command && !reverse_command);
   c_rev_start: cover property (sel_r == start_reverse_split ##1 run_command && reverse_command);
   c_pulse_run: cover property (sel_r == pulse_start_held_stop ##1 run_command);
   c_write_ctrl: cover property (do_write && addr_is(awaddr_r, ADDR_CTRL));

endmodule

// ---- tb/tb_start_stop_direction_decoder.sv ----
// self-checking bench of the start/stop/direction decoder over AXI4-Lite
module tb_start_stop_direction_decoder import cmd_decode_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;

   logic        aclk, aresetn, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
   logic        src1, src2, run, rev, panel;
   logic [31:0] awa, wd, ara, rdat, d;
   logic [3:0]  ws;
   logic [1:0]  bresp, rresp, r;
   int          failures, check_count;

   start_stop_direction_decoder dut_u (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .first_command_source(src1), .second_command_source(src2),
      .run_command(run), .reverse_command(rev), .panel_keys_enable(panel));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // address and data offered together, each dropped once taken
   // handshakes judged on values settled at the falling edge, so the readies
   // that drop at the taking edge are never misread; only the watchdog ends a wait
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s,
                         output logic [1:0] resp);
      logic       a_hit;
      logic       w_hit;
      logic       b_hit;
      logic [1:0] b_code;
      resp = 2'h3;
      @(posedge aclk);
      awa <= a;
      wd <= v;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      forever begin
         @(negedge aclk);
         a_hit  = awv && awr;
         w_hit  = wv && wrdy;
         b_hit  = bv;
         b_code = bresp;
         @(posedge aclk);
         if (a_hit) begin
            awv <= 1'b0;
         end
         if (w_hit) begin
            wv <= 1'b0;
         end
         if (b_hit) begin
            resp = b_code;
            br <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
      logic        ar_hit;
      logic        r_hit;
      logic [31:0] r_word;
      logic [1:0]  r_code;
      resp = 2'h3;
      v = 32'hx;
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      forever begin
         @(negedge aclk);
         ar_hit = arv && arr;
         r_hit  = rv;
         r_word = rdat;
         r_code = rresp;
         @(posedge aclk);
         if (ar_hit) begin
            arv <= 1'b0;
         end
         if (r_hit) begin
            v = r_word;
            resp = r_code;
            rr <= 1'b0;
            break;
         end
      end
   endtask

   task automatic mode(input logic [2:0] s, input logic k);
      axi_wr(ADDR_CTRL, (32'(k) << KIND_BIT) | 32'(s), 4'hf, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   // sources change once, then the decision has time to land
   task automatic src(input logic a, input logic b);
      @(posedge aclk);
      src1 <= a;
      src2 <= b;
      repeat (3) @(posedge aclk);
      #1;
   endtask

   // direction only matters while running
   task automatic outs(input logic ru, input logic re, input logic pk);
      check({29'h0, run, run & rev, panel}, {29'h0, ru, ru & re, pk});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   initial begin
      repeat (5000) @(posedge aclk);
      failures++;
      $display("[ERR] %0t ns: watchdog expired", $time);
      finish_test();
   end

   initial begin
      {aresetn, awv, wv, br, arv, rr, src1, src2} = '0;
      {awa, wd, ara} = '0;
      ws = 4'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      outs(1'b0, 1'b0, 1'b1);
      axi_rd(ADDR_CTRL, d, r);
      check(d, 32'(SEL_DEFAULT));
      $display("test reset done");
      mode(3'h1, KIND_EDGE);
      src(1, 0); outs(1, 0, 1);
      src(0, 0); outs(0, 0, 1);
      mode(3'h0, KIND_EDGE);
      src(1, 0); outs(0, 0, 1);
      mode(3'h1, KIND_EDGE);
      src(1, 0); outs(0, 0, 1);
      mode(3'h1, KIND_LEVEL);
      src(1, 0); outs(1, 0, 1);
      axi_rd(ADDR_STATUS, d, r);
      check(d & 32'h1d, 32'h0d);
      $display("test single source done");
      mode(3'h2, KIND_EDGE);
      src(0, 1); outs(0, 0, 1);
      src(1, 1); outs(1, 1, 1);
      src(0, 1); outs(0, 0, 1);
      src(1, 0); outs(1, 0, 1);
      src(0, 0);
      mode(3'h2, KIND_LEVEL);
      src(1, 1); outs(1, 1, 1);
      src(0, 0);
      $display("test direction input done");
      mode(3'h3, KIND_EDGE);
      src(0, 1); outs(1, 1, 1);
      src(0, 0); outs(0, 0, 1);
      src(1, 0); outs(1, 0, 1);
      src(1, 1); outs(0, 0, 1);
      src(0, 0);
      src(1, 1); outs(0, 0, 1);
      $display("test split start done");
      mode(3'h4, KIND_LEVEL);
      src(1, 1); outs(0, 0, 1);
      src(0, 1);
      src(1, 1); outs(1, 0, 1);
      src(1, 0); outs(0, 0, 0);
      src(0, 0);
      src(1, 0); outs(0, 0, 0);
      src(1, 1); outs(0, 0, 1);
      $display("test pulse start done");
      mode(3'h5, KIND_EDGE);
      src(0, 0);
      src(1, 0); outs(0, 0, 1);
      axi_rd(32'h0000_0008, d, r);
      check(d, 32'h0);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      axi_wr(32'h0000_000c, 32'h1, 4'hf, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      axi_wr(ADDR_STATUS, 32'hffff_ffff, 4'hf, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
      axi_wr(ADDR_CTRL, 32'h1, 4'h0, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
      axi_rd(ADDR_CTRL, d, r);
      check(d, 32'h5);
      axi_rd(ADDR_STATUS, d, r);
      check(d & 32'h1d, 32'h0c);
      $display("test register bus done");
      // source one held high across a second reset must read as a rise
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      #1;
      outs(1, 0, 1);
      axi_rd(ADDR_CTRL, d, r);
      check(d, 32'(SEL_DEFAULT));
      $display("test second reset done");
      finish_test();
   end

endmodule
